// file: pkg/mic_cfg.svh
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NUM_SRC      16
`define NUM_NMI      2
`define VEC_W        8
`define REG_W        8
`define ADDR_W       8
`define DATA_W       32
`define IDX_W        6
`define IDX_LSB      2

// ----------------------------------------------------------------
// Register indices, byte address is index times four
// ----------------------------------------------------------------
`define IDX_STATUS   6'h00
`define IDX_RR_VEC   6'h01
`define IDX_CTRL     6'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ST_NMI_EX    7
`define ST_HI_EX     2
`define ST_MED_EX    1
`define ST_LO_EX     0
`define CT_RR_EN     7
`define CT_VEC_SEL   6
`define CT_HI_EN     2
`define CT_MED_EN    1
`define CT_LO_EN     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STATUS_RST   8'h00
`define RR_VEC_RST   8'h00
`define CTRL_RST     8'h00
`define VEC_RST      8'h00
`define RDATA_RST    32'h0000_0000
`define RD_PAD       24'h00_0000

`endif

// file: pkg/mic_pkg.sv
`default_nettype none
package mic_pkg;
	// Request level, in its two-bit encoding order
	typedef enum logic [1:0] {
		LVL_OFF,
		LVL_LO,
		LVL_MED,
		LVL_HI
	} level_e;
	// Vector number
	typedef logic [7:0] vec_t;
endpackage
`default_nettype wire

// file: core/prio_pick.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Priority picker: lowest index wins, optional rotation past last
// ----------------------------------------------------------------
module prio_pick #(
	parameter int N = 16
) (
	input  wire logic [N-1:0] req_i,     // Pending requests
	input  wire logic         rr_en_i,   // Rotate after last winner
	input  wire logic [7:0]   last_i,    // Last winner, lowest rank
	output logic              found_o,   // Any request pending
	output logic [7:0]        idx_o      // Winning index
);
	logic       hit_up;   // Request above last winner
	logic [7:0] up_idx;   // Lowest index above last
	logic [7:0] all_idx;  // Lowest index overall

	// Scan downward so the lowest index is kept
	always_comb begin
		hit_up  = 1'b0;
		up_idx  = 8'h00;
		all_idx = 8'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				all_idx = 8'(i);
			end
			if (req_i[i] && (8'(i) > last_i)) begin
				up_idx = 8'(i);
				hit_up = 1'b1;
			end
		end
		found_o = |req_i;
		// Wrap to the bottom when nothing lies above last
		idx_o   = (rr_en_i && hit_up) ? up_idx : all_idx;
	end
endmodule
`default_nettype wire

// file: core/multilevel_irq_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "mic_cfg.svh"
module multilevel_irq_controller (
	input  wire logic                   ref_clk_i,             // System clock
	input  wire logic                   sys_rst_i,             // Async reset, high
	input  wire logic                   psel_i,                // APB select
	input  wire logic                   penable_i,             // APB enable
	input  wire logic                   pwrite_i,              // APB direction
	input  wire logic [`ADDR_W-1:0]     paddr_i,               // APB address
	input  wire logic [`DATA_W-1:0]     pwdata_i,              // APB write data
	input  wire logic [3:0]             pstrb_i,               // APB byte strobes
	output logic [`DATA_W-1:0]          prdata_o,              // APB read data
	output logic                        pready_o,              // APB ready
	output logic                        pslverr_o,             // APB error
	input  wire logic [`NUM_SRC-1:0]    src_req_i,             // Peripheral requests
	input  wire logic [2*`NUM_SRC-1:0]  src_level_i,           // Two bits per source
	input  wire logic [`NUM_NMI-1:0]    nmi_req_i,             // Non-maskable requests
	input  wire logic                   global_enable_i,       // Core global enable
	input  wire logic                   ccp_unlock_i,          // Protection unlocked
	input  wire logic                   irq_ack_i,             // Core takes vector
	input  wire logic                   return_from_handler_i, // Core return pulse
	output logic                        irq_valid_o,           // Vector offered
	output logic [`VEC_W-1:0]           irq_vector_o,          // Offered vector
	output logic [1:0]                  irq_level_o,           // Offered level
	output logic                        irq_nmi_o,             // Offered is NMI
	output logic                        vector_table_select_o  // Boot table chosen
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [`REG_W-1:0]  status_q, status_d;   // Executing flags
	logic [`REG_W-1:0]  rr_vec_q, rr_vec_d;   // Last low winner
	logic [`REG_W-1:0]  ctrl_q, ctrl_d;       // Enables and selects
	logic               valid_q, valid_d;     // Offer pending
	logic [`VEC_W-1:0]  vec_q, vec_d;         // Offered vector
	mic_pkg::level_e    lvl_q, lvl_d;         // Offered level
	logic               nmi_q, nmi_d;         // Offered NMI
	logic [`DATA_W-1:0] rdata_q, rdata_d;     // Read data
	logic               err_q, err_d;         // Error answer
	logic [`NUM_SRC-1:0] hi_req, med_req, lo_req; // Requests by level
	logic [`NUM_SRC-1:0] hi_pend, med_pend, lo_pend; // Enabled requests
	logic               nmi_fnd, hi_fnd, med_fnd, lo_fnd; // Picker hits
	logic [7:0]         nmi_idx, hi_idx, med_idx, lo_idx; // Picker winners
	logic               nmi_ok, hi_ok, med_ok, lo_ok; // Allowed to offer
	logic               took;                 // Offer acknowledged
	logic               setup;                // APB setup cycle
	logic               wr;                   // APB write takes effect
	logic [`IDX_W-1:0]  idx;                  // Register index
	logic               mapped;               // Address hits a register
	logic [`REG_W-1:0]  rd_byte;              // Selected register

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	// Split requests by their level
	always_comb begin
		for (int i = 0; i < `NUM_SRC; i++) begin
			hi_req[i]  = src_req_i[i] && (src_level_i[2*i +: 2] == 2'(mic_pkg::LVL_HI));
			med_req[i] = src_req_i[i] && (src_level_i[2*i +: 2] == 2'(mic_pkg::LVL_MED));
			lo_req[i]  = src_req_i[i] && (src_level_i[2*i +: 2] == 2'(mic_pkg::LVL_LO));
		end
	end

	assign hi_pend  = hi_req & {`NUM_SRC{ctrl_q[`CT_HI_EN]}};
	assign med_pend = med_req & {`NUM_SRC{ctrl_q[`CT_MED_EN]}};
	assign lo_pend  = lo_req & {`NUM_SRC{ctrl_q[`CT_LO_EN]}};

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	// NMI uses static order
	prio_pick #(.N(`NUM_NMI)) u_nmi_pick (
		.req_i   (nmi_req_i),
		.rr_en_i (1'b0),
		.last_i  (8'h00),
		.found_o (nmi_fnd),
		.idx_o   (nmi_idx)
	);
	prio_pick #(.N(`NUM_SRC)) u_hi_pick (
		.req_i   (hi_pend),
		.rr_en_i (1'b0),
		.last_i  (8'h00),
		.found_o (hi_fnd),
		.idx_o   (hi_idx)
	);
	prio_pick #(.N(`NUM_SRC)) u_med_pick (
		.req_i   (med_pend),
		.rr_en_i (1'b0),
		.last_i  (8'h00),
		.found_o (med_fnd),
		.idx_o   (med_idx)
	);
	prio_pick #(.N(`NUM_SRC)) u_lo_pick (
		.req_i   (lo_pend),
		.rr_en_i (ctrl_q[`CT_RR_EN]),
		.last_i  (rr_vec_q),
		.found_o (lo_fnd),
		.idx_o   (lo_idx)
	);

	// offer only above the running level
	always_comb begin
		nmi_ok = nmi_fnd && !status_q[`ST_NMI_EX];
		hi_ok  = hi_fnd && global_enable_i && !status_q[`ST_NMI_EX]
			&& !status_q[`ST_HI_EX];
		med_ok = med_fnd && global_enable_i && !status_q[`ST_NMI_EX]
			&& !status_q[`ST_HI_EX] && !status_q[`ST_MED_EX];
		lo_ok  = lo_fnd && global_enable_i && !status_q[`ST_NMI_EX]
			&& !status_q[`ST_HI_EX] && !status_q[`ST_MED_EX]
			&& !status_q[`ST_LO_EX];
	end

	assign took = irq_ack_i && valid_q;

	// Next offer, withdrawn for one cycle after an acknowledge
	always_comb begin
		valid_d = 1'b0;
		vec_d   = vec_q;
		lvl_d   = lvl_q;
		nmi_d   = 1'b0;
		if (!took) begin
			if (nmi_ok) begin
				valid_d = 1'b1;
				vec_d   = nmi_idx;
				lvl_d   = mic_pkg::LVL_HI;
				nmi_d   = 1'b1;
			end else if (hi_ok) begin
				valid_d = 1'b1;
				vec_d   = hi_idx;
				lvl_d   = mic_pkg::LVL_HI;
			end else if (med_ok) begin
				valid_d = 1'b1;
				vec_d   = med_idx;
				lvl_d   = mic_pkg::LVL_MED;
			end else if (lo_ok) begin
				valid_d = 1'b1;
				vec_d   = lo_idx;
				lvl_d   = mic_pkg::LVL_LO;
			end
		end
	end

	// Offer registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			valid_q <= 1'b0;
			vec_q   <= `VEC_RST;
			lvl_q   <= mic_pkg::LVL_OFF;
			nmi_q   <= 1'b0;
		end else begin
			valid_q <= valid_d;
			vec_q   <= vec_d;
			lvl_q   <= lvl_d;
			nmi_q   <= nmi_d;
		end
	end

	assign irq_valid_o  = valid_q;
	assign irq_vector_o = vec_q;
	assign irq_level_o  = 2'(lvl_q);
	assign irq_nmi_o    = nmi_q;

	// ----------------------------------------------------------------
	// APB slave and registers
	// ----------------------------------------------------------------
	assign idx    = paddr_i[`ADDR_W-1:`IDX_LSB];
	assign mapped = (paddr_i[`IDX_LSB-1:0] == 2'h0) && ((idx == `IDX_STATUS)
		|| (idx == `IDX_RR_VEC) || (idx == `IDX_CTRL));
	assign setup  = psel_i && !penable_i;
	assign wr     = psel_i && penable_i && pwrite_i && !err_q && pstrb_i[0];

	// Read mux, reserved bits read as zero
	always_comb begin
		unique case (idx)
			`IDX_STATUS: rd_byte = status_q;
			`IDX_RR_VEC: rd_byte = rr_vec_q;
			`IDX_CTRL:   rd_byte = ctrl_q;
			default:     rd_byte = 8'h00;
		endcase
	end

	// Register next values
	always_comb begin
		status_d = status_q;
		rr_vec_d = rr_vec_q;
		ctrl_d   = ctrl_q;
		rdata_d  = rdata_q;
		err_d    = err_q;
		// Answer prepared in setup, shown in access
		if (setup) begin
			rdata_d = {`RD_PAD, (mapped ? rd_byte : 8'h00)};
			err_d   = !mapped;
		end
		if (wr && (idx == `IDX_CTRL)) begin
			ctrl_d[`CT_RR_EN]  = pwdata_i[`CT_RR_EN];
			ctrl_d[`CT_HI_EN]  = pwdata_i[`CT_HI_EN];
			ctrl_d[`CT_MED_EN] = pwdata_i[`CT_MED_EN];
			ctrl_d[`CT_LO_EN]  = pwdata_i[`CT_LO_EN];
			if (ccp_unlock_i) begin
				ctrl_d[`CT_VEC_SEL] = pwdata_i[`CT_VEC_SEL];
			end
		end
		if (wr && (idx == `IDX_RR_VEC)) begin
			rr_vec_d = pwdata_i[`REG_W-1:0];
		end
		// return clears the highest active flag
		if (return_from_handler_i) begin
			if (status_q[`ST_NMI_EX]) begin
				status_d[`ST_NMI_EX] = 1'b0;
			end else if (status_q[`ST_HI_EX]) begin
				status_d[`ST_HI_EX] = 1'b0;
			end else if (status_q[`ST_MED_EX]) begin
				status_d[`ST_MED_EX] = 1'b0;
			end else begin
				status_d[`ST_LO_EX] = 1'b0;
			end
		end
		// Acknowledge sets a flag, winning over a clear
		if (took) begin
			if (nmi_q) begin
				status_d[`ST_NMI_EX] = 1'b1;
			end else if (lvl_q == mic_pkg::LVL_HI) begin
				status_d[`ST_HI_EX] = 1'b1;
			end else if (lvl_q == mic_pkg::LVL_MED) begin
				status_d[`ST_MED_EX] = 1'b1;
			end else begin
				status_d[`ST_LO_EX] = 1'b1;
				if (ctrl_q[`CT_RR_EN]) begin
					rr_vec_d = vec_q;
				end
			end
		end
	end

	// Register storage
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_q <= `STATUS_RST;
			rr_vec_q <= `RR_VEC_RST;
			ctrl_q   <= `CTRL_RST;
			rdata_q  <= `RDATA_RST;
			err_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			rr_vec_q <= rr_vec_d;
			ctrl_q   <= ctrl_d;
			rdata_q  <= rdata_d;
			err_q    <= err_d;
		end
	end

	assign prdata_o  = rdata_q;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && err_q;
	assign vector_table_select_o = ctrl_q[`CT_VEC_SEL];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_nmi_ret_clear: assert property (
		return_from_handler_i && status_q[`ST_NMI_EX] && !took
		|=> !status_q[`ST_NMI_EX] && ($past(status_q[`ST_HI_EX]) == status_q[`ST_HI_EX]))
		else $error("NMI return did not clear only the NMI flag");
	a_hi_held_nmi: assert property (
		status_q[`ST_HI_EX] && status_q[`ST_NMI_EX] |=> status_q[`ST_HI_EX])
		else $error("High flag lost under NMI");
	a_med_set_ack: assert property (
		took && !nmi_q && (lvl_q == mic_pkg::LVL_MED) |=> status_q[`ST_MED_EX])
		else $error("Medium flag not set on acknowledge");
	a_lo_held_pre: assert property (
		status_q[`ST_LO_EX] && status_q[`ST_MED_EX] |=> status_q[`ST_LO_EX])
		else $error("Low flag lost under preemption");
	a_rr_record: assert property (
		took && !nmi_q && (lvl_q == mic_pkg::LVL_LO) && ctrl_q[`CT_RR_EN]
		|=> rr_vec_q == $past(vec_q))
		else $error("Low winner not recorded");
	a_rr_last_low: assert property (
		ctrl_q[`CT_RR_EN] && (rr_vec_q < 8'(`NUM_SRC)) && lo_pend[rr_vec_q[3:0]]
		&& ((lo_pend & ~(16'h0001 << rr_vec_q[3:0])) != 16'h0000)
		|-> lo_idx != rr_vec_q)
		else $error("Recorded vector won over another low request");
	a_static_low: assert property (
		!ctrl_q[`CT_RR_EN] && lo_fnd
		|-> (lo_pend & ((16'h0001 << lo_idx[3:0]) - 16'h0001)) == 16'h0000)
		else $error("Static low order not lowest first");
	a_sel_locked: assert property (
		wr && (idx == `IDX_CTRL) && !ccp_unlock_i
		|=> $stable(ctrl_q[`CT_VEC_SEL]))
		else $error("Vector select changed without unlock");
	a_lo_ignored: assert property (
		!ctrl_q[`CT_LO_EN] |=> !(valid_q && !nmi_q && (lvl_q == mic_pkg::LVL_LO)))
		else $error("Low request offered while disabled");
	a_nmi_no_gie: assert property (
		nmi_fnd && !status_q[`ST_NMI_EX] && !took |=> valid_q && nmi_q)
		else $error("NMI not offered");
	a_ack_pause: assert property (
		took |=> !valid_q ##1 (!valid_q || (!$past(status_q[`ST_NMI_EX])
		&& (nmi_q || !$past(status_q[`ST_HI_EX])))))
		else $error("Offer not withdrawn or not above running level");

	c_rr_used: cover property (took && ctrl_q[`CT_RR_EN] && (lvl_q == mic_pkg::LVL_LO));
	c_nmi_over_hi: cover property (status_q[`ST_HI_EX] && took && nmi_q);
	c_ret_nest: cover property (status_q[`ST_MED_EX] && status_q[`ST_LO_EX]
		&& return_from_handler_i);
	c_bad_addr: cover property (psel_i && penable_i && err_q);
endmodule
`default_nettype wire

// file: bench/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Core model: takes offered vectors, signals handler returns
// ----------------------------------------------------------------
module core_model (
	input  wire logic ref_clk_i,   // System clock
	input  wire logic sys_rst_i,   // Async reset, high
	input  wire logic irq_valid_i, // Vector offered
	input  wire logic ack_en_i,    // Core may take offers
	input  wire logic slow_i,      // Core stalls before taking
	input  wire logic ret_req_i,   // Bench asks for a return
	output logic      irq_ack_o,   // Take pulse
	output logic      return_o     // Return pulse
);
	logic [1:0] wait_q; // Cycles the offer has stood
	logic [1:0] wait_d; // Next stall count
	logic       ack_d;  // Next take pulse
	logic       ret_d;  // Next return pulse

	// Take once per offer, after three cycles when slow
	always_comb begin
		wait_d = 2'h0;
		if (irq_valid_i && ack_en_i) begin
			wait_d = (wait_q == 2'h3) ? wait_q : wait_q + 2'h1;
		end
		ack_d = ack_en_i && irq_valid_i && !irq_ack_o && (!slow_i || wait_q == 2'h3);
		ret_d = ret_req_i && !return_o;
	end

	// Pulses leave a flop, so they change just after an edge
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_q <= 2'h0;
			irq_ack_o <= 1'b0;
			return_o <= 1'b0;
		end else begin
			wait_q <= wait_d;
			irq_ack_o <= ack_d;
			return_o <= ret_d;
		end
	end
endmodule
`default_nettype wire

// file: bench/multilevel_irq_controller_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mic_cfg.svh"
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module multilevel_irq_controller_bench;
	logic        ref_clk_i, sys_rst_i;                 // Clock, reset
	logic        psel_i, penable_i, pwrite_i;          // APB controls
	logic [7:0]  paddr_i;                              // APB address
	logic [31:0] pwdata_i, prdata_o;                   // APB data
	logic [3:0]  pstrb_i;                              // Byte strobes
	logic        pready_o, pslverr_o;                  // APB answer
	logic [15:0] src_req_i;                            // Source requests
	logic [31:0] src_level_i;                          // Source levels
	logic [1:0]  nmi_req_i, irq_level_o;               // NMI, offer level
	logic        global_enable_i, ccp_unlock_i;        // Core controls
	logic        irq_ack_i, return_from_handler_i;     // Core pulses
	logic        irq_valid_o, irq_nmi_o;               // Offer
	logic [7:0]  irq_vector_o;                         // Offered vector
	logic        vector_table_select_o;                // Table choice
	logic        ack_en, slow, ret_req;                // Core model controls
	logic [31:0] rd;                                   // Read data
	logic        er;                                   // Read error
	int          bad_count, check_count;               // Tallies

	multilevel_irq_controller i_dut (
		.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i, .prdata_o, .pready_o, .pslverr_o, .src_req_i, .src_level_i,
		.nmi_req_i, .global_enable_i, .ccp_unlock_i, .irq_ack_i, .return_from_handler_i,
		.irq_valid_o, .irq_vector_o, .irq_level_o, .irq_nmi_o, .vector_table_select_o
	);
	core_model i_core (
		.ref_clk_i, .sys_rst_i, .irq_valid_i(irq_valid_o), .ack_en_i(ack_en),
		.slow_i(slow), .ret_req_i(ret_req), .irq_ack_o(irq_ack_i),
		.return_o(return_from_handler_i)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compare and tally
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'h00_0000, wd};
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		// Ends once pready is sampled high; without it only the watchdog ends this wait
		do begin
			@(posedge ref_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Read a register and compare
	task automatic rchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(what, {24'h00_0000, exp}, rd);
	endtask

	// Let the core take the next offer and check what it took
	task automatic take(input logic [7:0] v, input logic [1:0] l, input logic nm);
		ack_en <= 1'b1;
		// A missing acknowledge is caught by the watchdog
		do begin
			@(posedge ref_clk_i);
		end while (!(irq_ack_i === 1'b1 && irq_valid_o === 1'b1));
		ack_en <= 1'b0;
		chk("vector", {24'h00_0000, v}, {24'h00_0000, irq_vector_o});
		chk("level", {30'h0000_0000, l}, {30'h0000_0000, irq_level_o});
		chk("nmi", {31'h0000_0000, nm}, {31'h0000_0000, irq_nmi_o});
	endtask

	// Core returns from the running handler
	task automatic ret();
		@(posedge ref_clk_i);
		ret_req <= 1'b1;
		@(posedge ref_clk_i);
		ret_req <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values, read-only status, unmapped place
	task automatic t_reset();
		rchk("status", `IDX_STATUS, 8'h00);
		rchk("rr", `IDX_RR_VEC, 8'h00);
		rchk("ctrl", `IDX_CTRL, 8'h00);
		apb(1'b1, `IDX_STATUS, 8'h87);
		rchk("status ro", `IDX_STATUS, 8'h00);
		apb(1'b0, 6'h03, 8'h00);
		chk("unmapped err", 32'h0000_0001, {31'h0000_0000, er});
		chk("unmapped data", 32'h0000_0000, rd);
		$display("test reset done");
	endtask

	// Each level enable, level off, and the one-cycle disable
	task automatic t_enable();
		global_enable_i <= 1'b1;
		src_req_i <= 16'h0010;
		src_level_i <= 32'h0000_0000;
		apb(1'b1, `IDX_CTRL, 8'h07);
		repeat (4) @(posedge ref_clk_i);
		chk("off level", 32'h0000_0000, {31'h0000_0000, irq_valid_o});
		for (int l = 1; l < 4; l++) begin
			src_level_i <= {22'h00_0000, l[1:0], 8'h00};
			apb(1'b1, `IDX_CTRL, 8'h07 & ~(8'h01 << (l - 1)));
			repeat (4) @(posedge ref_clk_i);
			chk("disabled", 32'h0000_0000, {31'h0000_0000, irq_valid_o});
			apb(1'b1, `IDX_CTRL, 8'h07);
			repeat (3) @(posedge ref_clk_i);
			chk("enabled", 32'h0000_0001, {31'h0000_0000, irq_valid_o});
			chk("en vector", 32'h0000_0004, {24'h00_0000, irq_vector_o});
			chk("en level", l, {30'h0000_0000, irq_level_o});
			apb(1'b1, `IDX_CTRL, 8'h07 & ~(8'h01 << (l - 1)));
			repeat (2) @(posedge ref_clk_i);
			chk("drop", 32'h0000_0000, {31'h0000_0000, irq_valid_o});
		end
		src_req_i <= 16'h0000;
		$display("test enable done");
	endtask

	// Rotating and static low-level order
	task automatic t_rr();
		apb(1'b1, `IDX_RR_VEC, 8'h00);
		apb(1'b1, `IDX_CTRL, 8'h81);
		src_level_i <= 32'h0000_0410;
		src_req_i <= 16'h0024;
		slow <= 1'b1;
		take(8'h02, 2'h1, 1'b0);
		rchk("rr last", `IDX_RR_VEC, 8'h02);
		rchk("lo exec", `IDX_STATUS, 8'h01);
		ret();
		take(8'h05, 2'h1, 1'b0);
		rchk("rr last", `IDX_RR_VEC, 8'h05);
		ret();
		apb(1'b1, `IDX_RR_VEC, 8'h02);
		take(8'h05, 2'h1, 1'b0);
		ret();
		apb(1'b1, `IDX_CTRL, 8'h01);
		rchk("rr kept", `IDX_RR_VEC, 8'h05);
		take(8'h02, 2'h1, 1'b0);
		ret();
		rchk("lo clear", `IDX_STATUS, 8'h00);
		src_req_i <= 16'h0000;
		slow <= 1'b0;
		apb(1'b1, `IDX_RR_VEC, 8'h00);
		$display("test round robin done");
	endtask

	// Nested preemption up to NMI, then unwinding
	task automatic t_nest();
		logic [7:0] st [4] = '{8'h07, 8'h03, 8'h01, 8'h00};
		apb(1'b1, `IDX_CTRL, 8'h07);
		src_level_i <= 32'h000C_2004;
		src_req_i <= 16'h0002;
		take(8'h01, 2'h1, 1'b0);
		src_req_i <= 16'h0040;
		take(8'h06, 2'h2, 1'b0);
		src_req_i <= 16'h0200;
		take(8'h09, 2'h3, 1'b0);
		src_req_i <= 16'h0000;
		global_enable_i <= 1'b0;
		nmi_req_i <= 2'b11;
		take(8'h00, 2'h3, 1'b1);
		nmi_req_i <= 2'b00;
		rchk("all exec", `IDX_STATUS, 8'h87);
		for (int i = 0; i < 4; i++) begin
			ret();
			rchk("unwind", `IDX_STATUS, st[i]);
		end
		global_enable_i <= 1'b1;
		$display("test nesting done");
	endtask

	// Vector table select behind the unlock
	task automatic t_vsel();
		apb(1'b1, `IDX_CTRL, 8'h41);
		rchk("locked", `IDX_CTRL, 8'h01);
		chk("sel locked", 32'h0000_0000, {31'h0000_0000, vector_table_select_o});
		ccp_unlock_i <= 1'b1;
		apb(1'b1, `IDX_CTRL, 8'h41);
		ccp_unlock_i <= 1'b0;
		rchk("unlocked", `IDX_CTRL, 8'h41);
		chk("sel boot", 32'h0000_0001, {31'h0000_0000, vector_table_select_o});
		ccp_unlock_i <= 1'b1;
		apb(1'b1, `IDX_CTRL, 8'h00);
		ccp_unlock_i <= 1'b0;
		@(posedge ref_clk_i);
		chk("sel app", 32'h0000_0000, {31'h0000_0000, vector_table_select_o});
		$display("test vector select done");
	endtask

	// ----------------------------------------------------------------
	// Verdict, clock, watchdog, main sequence
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// 250 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		end_sim();
	end

	// Reset, then every scenario in turn
	initial begin
		{psel_i, penable_i, pwrite_i, ack_en, slow, ret_req} = 6'h00;
		{global_enable_i, ccp_unlock_i} = 2'h0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		pstrb_i = 4'hf;
		src_req_i = 16'h0000;
		src_level_i = 32'h0000_0000;
		nmi_req_i = 2'h0;
		bad_count = 0;
		check_count = 0;
		sys_rst_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_enable();
		t_rr();
		t_nest();
		t_vsel();
		end_sim();
	end
endmodule
`default_nettype wire
